/* src/toc_pkg.sv */
// constants for the timer output compare unit
package toc_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_CTRL_C = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0c;
  localparam logic [7:0] ADDR_CMP_A_LO = 8'h10;
  localparam logic [7:0] ADDR_CMP_A_HI = 8'h14;
  localparam logic [7:0] ADDR_CMP_B_LO = 8'h18;
  localparam logic [7:0] ADDR_CMP_B_HI = 8'h1c;
  localparam logic [7:0] ADDR_FLAGS = 8'h20;
  localparam logic [7:0] ADDR_MASK = 8'h24;
  localparam logic [7:0] ADDR_SERVICE = 8'h28;
  localparam logic [7:0] ADDR_STATE = 8'h2c;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_A_WGM_LO = 0;
  localparam int CTRL_A_COMB = 4;
  localparam int CTRL_A_COMA = 6;
  localparam int CTRL_B_CS = 0;
  localparam int CTRL_B_WGM_HI = 3;
  localparam int CTRL_C_FOCB = 6;
  localparam int CTRL_C_FOCA = 7;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;
  // ****************************************
  // modes and values
  // ****************************************
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_A = 4'h4;
  localparam logic [3:0] WGM_CTC_ICR = 4'hc;
  localparam logic [3:0] WGM_FAST_A = 4'hf;
  localparam logic [3:0] WGM_PHASE_A = 4'hb;
  localparam logic [3:0] WGM_PFC_A = 4'h9;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {ACT_NONE, ACT_SET, ACT_CLEAR, ACT_TOGGLE} toc_act_type;
endpackage

/* src/toc_channel.sv */
// one compare channel: double buffer, match and output state
module toc_channel (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // cpu side
  input wire logic wr_value,
  input wire logic [15:0] wr_data,
  input wire logic force_strobe,
  // counter side
  input wire logic [15:0] count,
  input wire logic tick,
  input wire logic block_match,
  input wire logic buffered,
  input wire logic load_point,
  input wire logic pwm_mode,
  input wire logic count_down,
  input wire logic at_bottom,
  input wire logic [1:0] out_mode,
  // results
  output logic [15:0] value_read,
  output logic [15:0] active_value,
  output logic match_event,
  output logic out_state
);
  logic [15:0] buf_r;
  logic [15:0] cmp_r;
  logic oc_r;
  logic oc_nxt;
  logic [15:0] buf_nxt;
  logic [15:0] cmp_nxt;
  logic equal;
  logic act_match;
  toc_pkg::toc_act_type act;

  // match only counts on a tick and not right after a counter write
  assign equal = (count == cmp_r);
  assign act_match = equal && tick && !block_match;
  assign match_event = act_match;
  // reads see buffer in buffered modes, else the compare register itself
  assign value_read = buffered ? buf_r : cmp_r;
  assign active_value = cmp_r;

  // waveform action from mode; single-slope pwm uses bottom for the opposite edge, dual-slope the match while counting down
  always_comb begin
    act = toc_pkg::ACT_NONE;
    if (act_match || (force_strobe && !pwm_mode)) begin
      case (out_mode)
        toc_pkg::COM_TOGGLE: act = pwm_mode ? toc_pkg::ACT_NONE : toc_pkg::ACT_TOGGLE;
        toc_pkg::COM_CLEAR: act = pwm_mode && count_down ? toc_pkg::ACT_SET
                                                         : toc_pkg::ACT_CLEAR;
        toc_pkg::COM_SET: act = pwm_mode && count_down ? toc_pkg::ACT_CLEAR
                                                       : toc_pkg::ACT_SET;
        default: act = toc_pkg::ACT_NONE;
      endcase
    end else if (pwm_mode && tick && at_bottom && !count_down) begin
      case (out_mode)
        toc_pkg::COM_CLEAR: act = toc_pkg::ACT_SET;
        toc_pkg::COM_SET: act = toc_pkg::ACT_CLEAR;
        default: act = toc_pkg::ACT_NONE;
      endcase
    end
  end

  always_comb begin
    case (act)
      toc_pkg::ACT_SET: oc_nxt = 1'b1;
      toc_pkg::ACT_CLEAR: oc_nxt = 1'b0;
      toc_pkg::ACT_TOGGLE: oc_nxt = !oc_r;
      default: oc_nxt = oc_r;
    endcase
  end

  // only cpu writes change the value; buffer copies at top or bottom
  assign buf_nxt = (wr_value && buffered) ? wr_data : buf_r;
  assign cmp_nxt = (wr_value && !buffered) ? wr_data :
                   (buffered && load_point) ? buf_r : cmp_r;

  // state flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_r <= toc_pkg::RESET_WORD;
      cmp_r <= toc_pkg::RESET_WORD;
      oc_r <= 1'b0;
    end else begin
      buf_r <= buf_nxt;
      cmp_r <= cmp_nxt;
      oc_r <= oc_nxt;
    end
  end
  assign out_state = oc_r;
endmodule

/* src/toc_top.sv */
// 16-bit timer with two output compare channels behind an apb slave
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
module toc_top #(
  parameter int PRESCALE = 1
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // port pins
  input wire logic [1:0] PORT_VALUE,
  input wire logic [1:0] PORT_DIR,
  output logic [1:0] PIN_OUT,
  output logic [1:0] PIN_OE,
  // interrupt requests and service acknowledges
  output logic IRQ_CMP_A,
  output logic IRQ_CMP_B,
  output logic IRQ_OVF,
  input wire logic ACK_CMP_A,
  input wire logic ACK_CMP_B,
  input wire logic ACK_OVF
);
  // the prescaler counter is sixteen bits wide, so larger ratios cannot be served
  if (PRESCALE < 1 || PRESCALE > 65536) begin : g_bad_prescale
    $error("PRESCALE must lie between 1 and 65536");
  end

  // ****************************************
  // apb decode
  // ****************************************
  logic wr;
  logic rd_ok;
  logic w_ctrl_a;
  logic w_ctrl_b;
  logic w_ctrl_c;
  logic w_count;
  logic w_a_lo;
  logic w_a_hi;
  logic w_b_lo;
  logic w_b_hi;
  logic w_flags;
  logic w_mask;
  logic w_serv;
  logic [7:0] wb;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  assign wr = PSEL && PENABLE && PWRITE;
  assign wb = PWDATA[7:0];
  assign w_ctrl_a = wr && hit(PADDR, toc_pkg::ADDR_CTRL_A);
  assign w_ctrl_b = wr && hit(PADDR, toc_pkg::ADDR_CTRL_B);
  assign w_ctrl_c = wr && hit(PADDR, toc_pkg::ADDR_CTRL_C);
  assign w_count = wr && hit(PADDR, toc_pkg::ADDR_COUNT);
  assign w_a_lo = wr && hit(PADDR, toc_pkg::ADDR_CMP_A_LO);
  assign w_a_hi = wr && hit(PADDR, toc_pkg::ADDR_CMP_A_HI);
  assign w_b_lo = wr && hit(PADDR, toc_pkg::ADDR_CMP_B_LO);
  assign w_b_hi = wr && hit(PADDR, toc_pkg::ADDR_CMP_B_HI);
  assign w_flags = wr && hit(PADDR, toc_pkg::ADDR_FLAGS);
  assign w_mask = wr && hit(PADDR, toc_pkg::ADDR_MASK);
  assign w_serv = wr && hit(PADDR, toc_pkg::ADDR_SERVICE);
  assign rd_ok = hit(PADDR, toc_pkg::ADDR_CTRL_A) || hit(PADDR, toc_pkg::ADDR_CTRL_B) ||
                 hit(PADDR, toc_pkg::ADDR_CTRL_C) || hit(PADDR, toc_pkg::ADDR_COUNT) ||
                 hit(PADDR, toc_pkg::ADDR_CMP_A_LO) || hit(PADDR, toc_pkg::ADDR_CMP_A_HI) ||
                 hit(PADDR, toc_pkg::ADDR_CMP_B_LO) || hit(PADDR, toc_pkg::ADDR_CMP_B_HI) ||
                 hit(PADDR, toc_pkg::ADDR_FLAGS) || hit(PADDR, toc_pkg::ADDR_MASK) ||
                 hit(PADDR, toc_pkg::ADDR_SERVICE) || hit(PADDR, toc_pkg::ADDR_STATE);
  // zero wait states; unmapped addresses answer with an error
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !rd_ok;

  // ****************************************
  // control registers
  // ****************************************
  logic [7:0] timer_ctrl_a_r;
  logic [7:0] timer_ctrl_b_r;
  logic [7:0] temp_hi_r;
  logic [2:0] timer_irq_mask_reg_r;
  logic [3:0] waveform_mode_sel;
  logic [1:0] com_a;
  logic [1:0] com_b;
  logic [2:0] clk_sel;

  assign waveform_mode_sel = {timer_ctrl_b_r[toc_pkg::CTRL_B_WGM_HI +: 2],
                              timer_ctrl_a_r[toc_pkg::CTRL_A_WGM_LO +: 2]};
  assign com_a = timer_ctrl_a_r[toc_pkg::CTRL_A_COMA +: 2];
  assign com_b = timer_ctrl_a_r[toc_pkg::CTRL_A_COMB +: 2];
  assign clk_sel = timer_ctrl_b_r[toc_pkg::CTRL_B_CS +: 3];

  // output mode changes act at once, no buffering
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      timer_ctrl_a_r <= 8'h00;
      timer_ctrl_b_r <= 8'h00;
      timer_irq_mask_reg_r <= 3'h0;
    end else begin
      if (w_ctrl_a) timer_ctrl_a_r <= wb;
      if (w_ctrl_b) timer_ctrl_b_r <= wb;
      if (w_mask) timer_irq_mask_reg_r <= wb[2:0];
    end
  end

  // shared high byte latch, filled by either high byte write
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) temp_hi_r <= 8'h00;
    else if (w_a_hi || w_b_hi) temp_hi_r <= wb;
  end

  // ****************************************
  // timer tick from the prescaler
  // ****************************************
  logic [15:0] pre_r;
  logic tick;
  logic pre_wrap;
  assign pre_wrap = (pre_r == 16'(PRESCALE - 1));
  assign tick = (clk_sel != toc_pkg::CS_STOP) && pre_wrap;
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) pre_r <= 16'h0000;
    else if (clk_sel == toc_pkg::CS_STOP || pre_wrap) pre_r <= 16'h0000;
    else pre_r <= pre_r + 16'h0001;
  end

  // ****************************************
  // mode decode
  // ****************************************
  logic pwm_mode;
  logic a_is_top;
  logic dual_slope;
  logic [15:0] top_val;
  logic [15:0] cmp_a_act;
  logic [15:0] timer_count_r;
  logic dir_down_r;
  logic at_top;
  logic at_bottom;
  logic load_point;

  // pwm is everything except normal and the two clear-on-match modes
  assign pwm_mode = !(waveform_mode_sel == toc_pkg::WGM_NORMAL ||
                      waveform_mode_sel == toc_pkg::WGM_CTC_A ||
                      waveform_mode_sel == toc_pkg::WGM_CTC_ICR);
  assign a_is_top = (waveform_mode_sel == toc_pkg::WGM_CTC_A) ||
                    (waveform_mode_sel == toc_pkg::WGM_FAST_A) ||
                    (waveform_mode_sel == toc_pkg::WGM_PHASE_A) ||
                    (waveform_mode_sel == toc_pkg::WGM_PFC_A);
  assign dual_slope = (waveform_mode_sel == toc_pkg::WGM_PHASE_A) ||
                      (waveform_mode_sel == toc_pkg::WGM_PFC_A);
  // other modes have no top source here, so they run to max
  assign top_val = a_is_top ? cmp_a_act : toc_pkg::COUNT_MAX;
  assign at_top = (timer_count_r == top_val);
  assign at_bottom = (timer_count_r == toc_pkg::COUNT_BOTTOM);
  assign load_point = tick && (dual_slope ? at_bottom : at_top);

  // ****************************************
  // counter
  // ****************************************
  logic [15:0] count_nxt;
  logic dir_nxt;
  logic block_r;
  logic [15:0] count_wdata;

  assign count_wdata = PWDATA[15:0];
  always_comb begin
    count_nxt = timer_count_r;
    dir_nxt = dir_down_r;
    if (w_count) begin
      count_nxt = count_wdata;
    end else if (tick) begin
      if (dual_slope) begin
        if (!dir_down_r && at_top) begin
          dir_nxt = 1'b1;
          count_nxt = timer_count_r - 16'h0001;
        end else if (dir_down_r && at_bottom) begin
          dir_nxt = 1'b0;
          count_nxt = timer_count_r + 16'h0001;
        end else begin
          count_nxt = dir_down_r ? timer_count_r - 16'h0001 : timer_count_r + 16'h0001;
        end
      end else if (a_is_top && at_top) begin
        count_nxt = toc_pkg::COUNT_BOTTOM;
      end else begin
        count_nxt = timer_count_r + 16'h0001;
      end
    end
  end

  // a counter write arms blocking until the next tick has passed
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      timer_count_r <= toc_pkg::RESET_WORD;
      dir_down_r <= 1'b0;
      block_r <= 1'b0;
    end else begin
      timer_count_r <= count_nxt;
      dir_down_r <= dir_nxt;
      if (w_count) block_r <= 1'b1;
      else if (tick) block_r <= 1'b0;
    end
  end

  // ****************************************
  // channels
  // ****************************************
  logic [1:0] match;
  logic [1:0] oc_state;
  logic [15:0] rd_a;
  logic [15:0] rd_b;
  logic force_a;
  logic force_b;
  logic [15:0] cmp_wdata;

  assign cmp_wdata = {temp_hi_r, wb};
  assign force_a = w_ctrl_c && wb[toc_pkg::CTRL_C_FOCA];
  assign force_b = w_ctrl_c && wb[toc_pkg::CTRL_C_FOCB];

  toc_channel u_cha (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .wr_value(w_a_lo),
    .wr_data(cmp_wdata),
    .force_strobe(force_a),
    .count(timer_count_r),
    .tick(tick),
    .block_match(block_r),
    .buffered(pwm_mode),
    .load_point(load_point),
    .pwm_mode(pwm_mode),
    .count_down(dir_down_r),
    .at_bottom(at_bottom),
    .out_mode(com_a),
    .value_read(rd_a),
    .active_value(cmp_a_act),
    .match_event(match[0]),
    .out_state(oc_state[0])
  );

  toc_channel u_chb (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .wr_value(w_b_lo),
    .wr_data(cmp_wdata),
    .force_strobe(force_b),
    .count(timer_count_r),
    .tick(tick),
    .block_match(block_r),
    .buffered(pwm_mode),
    .load_point(load_point),
    .pwm_mode(pwm_mode),
    .count_down(dir_down_r),
    .at_bottom(at_bottom),
    .out_mode(com_b),
    .value_read(rd_b),
    .active_value(),
    .match_event(match[1]),
    .out_state(oc_state[1])
  );

  // ****************************************
  // flags and interrupt requests
  // ****************************************
  logic [2:0] timer_flag_reg_r;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic [2:0] ack;
  logic wrap;

  // overflow on the tick where the count goes from max to zero
  assign wrap = tick && !w_count && (timer_count_r == toc_pkg::COUNT_MAX) && !dual_slope;
  assign flag_set = {match[1], match[0], wrap};
  assign ack = {ACK_CMP_B, ACK_CMP_A, ACK_OVF};
  // write one to clear, or clear on service; a same-cycle set wins
  assign flag_clr = (w_flags ? wb[2:0] : 3'h0) | ack | (w_serv ? wb[2:0] : 3'h0);

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) timer_flag_reg_r <= 3'h0;
    else timer_flag_reg_r <= flag_set | (timer_flag_reg_r & ~flag_clr);
  end

  assign IRQ_OVF = timer_flag_reg_r[toc_pkg::FLAG_OVF] && timer_irq_mask_reg_r[toc_pkg::FLAG_OVF];
  assign IRQ_CMP_A = timer_flag_reg_r[toc_pkg::FLAG_CMPA] &&
                     timer_irq_mask_reg_r[toc_pkg::FLAG_CMPA];
  assign IRQ_CMP_B = timer_flag_reg_r[toc_pkg::FLAG_CMPB] &&
                     timer_irq_mask_reg_r[toc_pkg::FLAG_CMPB];

  // ****************************************
  // port override
  // ****************************************
  // direction always stays with the port; only the value is replaced
  assign PIN_OUT[0] = (com_a != toc_pkg::COM_OFF) ? oc_state[0] : PORT_VALUE[0];
  assign PIN_OUT[1] = (com_b != toc_pkg::COM_OFF) ? oc_state[1] : PORT_VALUE[1];
  assign PIN_OE = PORT_DIR;

  // ****************************************
  // read mux
  // ****************************************
  logic [31:0] rd_mux;
  always_comb begin
    case (PADDR)
      toc_pkg::ADDR_CTRL_A: rd_mux = {24'h000000, timer_ctrl_a_r};
      toc_pkg::ADDR_CTRL_B: rd_mux = {24'h000000, timer_ctrl_b_r};
      toc_pkg::ADDR_CTRL_C: rd_mux = toc_pkg::RD_ZERO;
      toc_pkg::ADDR_COUNT: rd_mux = {16'h0000, timer_count_r};
      toc_pkg::ADDR_CMP_A_LO: rd_mux = {24'h000000, rd_a[7:0]};
      toc_pkg::ADDR_CMP_A_HI: rd_mux = {24'h000000, rd_a[15:8]};
      toc_pkg::ADDR_CMP_B_LO: rd_mux = {24'h000000, rd_b[7:0]};
      toc_pkg::ADDR_CMP_B_HI: rd_mux = {24'h000000, rd_b[15:8]};
      toc_pkg::ADDR_FLAGS: rd_mux = {29'h00000000, timer_flag_reg_r};
      toc_pkg::ADDR_MASK: rd_mux = {29'h00000000, timer_irq_mask_reg_r};
      toc_pkg::ADDR_STATE: rd_mux = {30'h00000000, oc_state};
      default: rd_mux = toc_pkg::RD_ZERO;
    endcase
  end

  // read data registered in the setup cycle, valid during access
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) PRDATA <= toc_pkg::RD_ZERO;
    else if (PSEL && !PENABLE && !PWRITE) PRDATA <= rd_mux;
  end
endmodule

/* testbench/toc_top_chk.sv */
// port-level assertion checker for the timer output compare unit
// ****************************************
// checker
// ****************************************
module toc_top_chk #(
  parameter int PRESCALE = 1
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // port pins
  input wire logic [1:0] PORT_VALUE,
  input wire logic [1:0] PORT_DIR,
  input wire logic [1:0] PIN_OUT,
  input wire logic [1:0] PIN_OE,
  // interrupts
  input wire logic IRQ_CMP_A,
  input wire logic IRQ_CMP_B,
  input wire logic IRQ_OVF,
  input wire logic ACK_CMP_A,
  input wire logic ACK_CMP_B,
  input wire logic ACK_OVF
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);
  logic [7:0] ctrl_a_r;
  logic [7:0] mask_r;
  // access decode
  wire acc = PSEL && PENABLE;
  wire wr_acc = acc && PWRITE;
  wire rd_acc = acc && !PWRITE;
  wire mapped = (PADDR <= toc_pkg::ADDR_STATE) && (PADDR[1:0] == 2'h0);
  wire com_a_off = ctrl_a_r[toc_pkg::CTRL_A_COMA +: 2] == toc_pkg::COM_OFF;
  wire com_b_off = ctrl_a_r[toc_pkg::CTRL_A_COMB +: 2] == toc_pkg::COM_OFF;
  // shadows of the writable control bits the pins and irqs depend on
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_a_r <= 8'h00;
      mask_r <= 8'h00;
    end else if (wr_acc && PADDR == toc_pkg::ADDR_CTRL_A) begin
      ctrl_a_r <= PWDATA[7:0];
    end else if (wr_acc && PADDR == toc_pkg::ADDR_MASK) begin
      mask_r <= PWDATA[7:0];
    end
  end
  AST_PIN_DIR: assert property (PIN_OE == PORT_DIR)
    else $error("pin enable differs from port direction");
  AST_PIN_PORT: assert property (com_a_off |-> PIN_OUT[0] == PORT_VALUE[0])
    else $error("pin a not following port value");
  AST_PIN_PORT_B: assert property (com_b_off |-> PIN_OUT[1] == PORT_VALUE[1])
    else $error("pin b not following port value");
  AST_RST_IRQ: assert property ($rose(RESETN) |-> !IRQ_OVF && !IRQ_CMP_A && !IRQ_CMP_B)
    else $error("interrupt raised straight after reset");
  AST_MASK_A: assert property (!mask_r[toc_pkg::FLAG_CMPA] |-> !IRQ_CMP_A)
    else $error("compare a irq while masked");
  AST_MASK_OVF: assert property (!mask_r[toc_pkg::FLAG_OVF] |-> !IRQ_OVF)
    else $error("overflow irq while masked");
  AST_ACK_A: assert property (ACK_CMP_A |=> !IRQ_CMP_A)
    else $error("service left compare a flag set");
  AST_W1C_A: assert property (wr_acc && PADDR == toc_pkg::ADDR_FLAGS && PWDATA[1] |=> !IRQ_CMP_A)
    else $error("write one did not clear compare a flag");
  AST_FORCE_ZERO: assert property (rd_acc && PADDR == toc_pkg::ADDR_CTRL_C |-> PRDATA == toc_pkg::RD_ZERO)
    else $error("force strobes read nonzero");
  AST_SLVERR: assert property (acc |-> PSLVERR == !mapped)
    else $error("error response wrong for address");
  AST_UNMAP_RD: assert property (rd_acc && !mapped |-> PRDATA == toc_pkg::RD_ZERO)
    else $error("unmapped read returned data");
endmodule

bind toc_top toc_top_chk #(.PRESCALE(PRESCALE)) chk_u (
  .CLK_SYS(CLK_SYS), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PORT_VALUE(PORT_VALUE), .PORT_DIR(PORT_DIR), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
  .IRQ_CMP_A(IRQ_CMP_A), .IRQ_CMP_B(IRQ_CMP_B), .IRQ_OVF(IRQ_OVF),
  .ACK_CMP_A(ACK_CMP_A), .ACK_CMP_B(ACK_CMP_B), .ACK_OVF(ACK_OVF)
);

/* testbench/toc_svc_model.sv */
// cpu-side service model: acknowledges pending interrupt requests
module toc_svc_model #(
  parameter int DELAY = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // requests and acknowledges
  input wire logic en,
  input wire logic [2:0] irq,
  output logic [2:0] ack
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned wait_r;
  wire pend = en && (irq != 3'h0) && (ack == 3'h0);
  // a handler takes a few cycles to get round to servicing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 3'h0;
      wait_r <= 0;
    end else if (pend && wait_r == DELAY) begin
      ack <= irq;
      wait_r <= 0;
    end else begin
      ack <= 3'h0;
      wait_r <= pend ? wait_r + 1 : 0;
    end
  end
endmodule

/* testbench/toc_top_tb.sv */
// self-checking bench for the timer output compare unit
module toc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] port_value = 2'h2;
  logic [1:0] port_dir = 2'h0;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [2:0] irq;
  logic [2:0] ack;
  logic svc_en = 1'b0;
  logic [31:0] rd_val;
  logic err_val;
  // a toggles on match, b clears on match
  localparam logic [7:0] CTRL_A_RUN = {toc_pkg::COM_TOGGLE, toc_pkg::COM_CLEAR, 4'h0};
  int bad_count = 0;
  int num_checks = 0;
  // 100 mhz system clock
  always #5 clk_sys = ~clk_sys;
  toc_top #(.PRESCALE(1)) dut_u (
    .CLK_SYS(clk_sys), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PORT_VALUE(port_value), .PORT_DIR(port_dir), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .IRQ_OVF(irq[0]), .IRQ_CMP_A(irq[1]), .IRQ_CMP_B(irq[2]),
    .ACK_OVF(ack[0]), .ACK_CMP_A(ack[1]), .ACK_CMP_B(ack[2])
  );
  toc_svc_model #(.DELAY(3)) svc_u (
    .clk(clk_sys), .rst_n(rst_n), .en(svc_en), .irq(irq), .ack(ack)
  );
  // ****************************************
  // tasks
  // ****************************************
  // one apb transfer; leading edge keeps drivers from double assignment
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd_val = prdata;
    err_val = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_val, exp);
  endtask
  // pins sampled mid-cycle, after the edge has settled
  task automatic pins(input logic [1:0] exp_out);
    @(negedge clk_sys);
    chk({30'h0, pin_out}, {30'h0, exp_out});
    chk({30'h0, pin_oe}, {30'h0, port_dir});
  endtask
  task automatic wait_lvl(input int b, input logic lvl);
    int n;
    n = 0;
    while (irq[b] !== lvl && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk({31'h0, irq[b]}, {31'h0, lvl});
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    pins(2'h2);
    rd_chk(toc_pkg::ADDR_STATE, 32'h0);
    rd_chk(toc_pkg::ADDR_FLAGS, 32'h0);
    rd_chk(8'h30, 32'h0);
    chk({31'h0, err_val}, 32'h1);
    // high byte waits in the shared latch until the low write
    wr(toc_pkg::ADDR_CMP_B_HI, 32'h12);
    wr(toc_pkg::ADDR_CMP_B_LO, 32'h34);
    wr(toc_pkg::ADDR_CMP_A_HI, 32'h00);
    rd_chk(toc_pkg::ADDR_CMP_B_HI, 32'h12);
    rd_chk(toc_pkg::ADDR_CMP_B_LO, 32'h34);
    wr(toc_pkg::ADDR_CMP_A_LO, 32'h20);
    rd_chk(toc_pkg::ADDR_CMP_A_LO, 32'h20);
    // force with output mode off does nothing
    wr(toc_pkg::ADDR_CTRL_C, 32'hc0);
    rd_chk(toc_pkg::ADDR_STATE, 32'h0);
    rd_chk(toc_pkg::ADDR_CTRL_C, 32'h0);
    // force flips state a and clears state b, no flag
    wr(toc_pkg::ADDR_CTRL_A, {24'h0, CTRL_A_RUN});
    wr(toc_pkg::ADDR_CTRL_C, 32'hc0);
    rd_chk(toc_pkg::ADDR_STATE, 32'h1);
    rd_chk(toc_pkg::ADDR_FLAGS, 32'h0);
    // pin turned to output only once its state is set up
    port_dir <= 2'h1;
    pins(2'h1);
    // pwm mode with the clock stopped: writes wait in the buffer
    wr(toc_pkg::ADDR_CTRL_A, {24'h0, CTRL_A_RUN | 8'h03});
    wr(toc_pkg::ADDR_CMP_A_HI, 32'h00);
    wr(toc_pkg::ADDR_CMP_A_LO, 32'h55);
    rd_chk(toc_pkg::ADDR_CMP_A_LO, 32'h55);
    wr(toc_pkg::ADDR_CTRL_A, {24'h0, CTRL_A_RUN});
    rd_chk(toc_pkg::ADDR_CMP_A_LO, 32'h20);
    rd_chk(toc_pkg::ADDR_STATE, 32'h1);
    // counter loaded with the compare value loses that match
    wr(toc_pkg::ADDR_COUNT, 32'h20);
    wr(toc_pkg::ADDR_CTRL_B, 32'h1);
    wr(toc_pkg::ADDR_CTRL_B, 32'h0);
    rd_chk(toc_pkg::ADDR_FLAGS, 32'h0);
    // three ticks ran between the two control writes, then it holds
    rd_chk(toc_pkg::ADDR_COUNT, 32'h23);
    rd_chk(toc_pkg::ADDR_COUNT, 32'h23);
    // real match: flag, irq and toggle back to zero
    wr(toc_pkg::ADDR_MASK, 32'h2);
    wr(toc_pkg::ADDR_COUNT, 32'h1c);
    wr(toc_pkg::ADDR_CTRL_B, 32'h1);
    wait_lvl(1, 1'b1);
    wr(toc_pkg::ADDR_CTRL_B, 32'h0);
    rd_chk(toc_pkg::ADDR_STATE, 32'h0);
    wr(toc_pkg::ADDR_FLAGS, 32'h0);
    rd_chk(toc_pkg::ADDR_FLAGS, 32'h2);
    wr(toc_pkg::ADDR_FLAGS, 32'h2);
    rd_chk(toc_pkg::ADDR_FLAGS, 32'h0);
    // the service model clears the flag by acknowledging
    svc_en <= 1'b1;
    wr(toc_pkg::ADDR_COUNT, 32'h1c);
    wr(toc_pkg::ADDR_CTRL_B, 32'h1);
    wait_lvl(1, 1'b1);
    wait_lvl(1, 1'b0);
    wr(toc_pkg::ADDR_CTRL_B, 32'h0);
    svc_en <= 1'b0;
    // wrap from the top sets overflow
    wr(toc_pkg::ADDR_MASK, 32'h1);
    wr(toc_pkg::ADDR_COUNT, 32'hfff0);
    wr(toc_pkg::ADDR_CTRL_B, 32'h1);
    wait_lvl(0, 1'b1);
    wr(toc_pkg::ADDR_CTRL_B, 32'h0);
    apb(1'b0, toc_pkg::ADDR_COUNT, 32'h0);
    chk(rd_val & 32'hffff_ff00, 32'h0);
    rd_chk(toc_pkg::ADDR_FLAGS, 32'h1);
    wr(toc_pkg::ADDR_SERVICE, 32'h1);
    rd_chk(toc_pkg::ADDR_FLAGS, 32'h0);
    // channel b match raises its own flag and request
    wr(toc_pkg::ADDR_MASK, 32'h4);
    wr(toc_pkg::ADDR_COUNT, 32'h1230);
    wr(toc_pkg::ADDR_CTRL_B, 32'h1);
    wait_lvl(2, 1'b1);
    wr(toc_pkg::ADDR_CTRL_B, 32'h0);
    rd_chk(toc_pkg::ADDR_FLAGS, 32'h4);
    wr(toc_pkg::ADDR_FLAGS, 32'h4);
    wait_lvl(2, 1'b0);
    give_verdict();
  end
  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
